// ---- design/irq_unit_regs.vh ----
// Register indices, field positions, reset values and fixed addresses of the interrupt unit.
`ifndef IRQ_UNIT_REGS_VH
`define IRQ_UNIT_REGS_VH

// ------------------------------------------------------------
// Register indices; the bus byte address is four times the index.
// ------------------------------------------------------------
`define IDX_PRIORITY_ORDER 10'h0F9
`define IDX_REQUEST_EDGE 10'h0FA
`define IDX_MASK 10'h0FB
`define IDX_EVT_STATUS 10'h100
`define IDX_EVT_CLEAR 10'h101
`define IDX_EVT_ENABLE 10'h102

// ------------------------------------------------------------
// Field positions.
// ------------------------------------------------------------
`define REQ_EDGE_CH2_BIT 7
`define REQ_EDGE_CH0_BIT 6
`define MASK_GLOBAL_BIT 7
`define PRI_START_MSB 2

// ------------------------------------------------------------
// Reset values.
// ------------------------------------------------------------
`define RST_REQUEST 6'h00
`define RST_EDGE 2'h0
`define RST_MASK 8'h00
`define RST_PRIORITY 3'h0
`define RST_EVT 6'h00

// ------------------------------------------------------------
// Program memory layout and channel count.
// ------------------------------------------------------------
`define NUM_CHANNELS 6
`define PC_RESET_ADDR 16'h000C
`define VECTOR_BASE 16'h0000

// ------------------------------------------------------------
// AHB-Lite encodings.
// ------------------------------------------------------------
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`define HRESP_OKAY 1'b0

`endif

// ---- design/six_source_vectored_interrupt_unit.v ----
// Six-channel vectored, maskable, prioritized interrupt unit with an AHB-Lite register port.
`timescale 1ns/1ps
`include "irq_unit_regs.vh"

// Operation
// R1 - Six maskable, prioritized interrupt channels.
// R2 - Port-three pins on zero-three; timers four, five.
// R3 - Vector n at program bytes 2n, 2n+1.
// R4 - Channel zero: selectable pin edge plus port-zero ready.
// R5 - Channel one: falling pin edge only.
// R6 - Channel two: selectable edge, timer input, port-two ready.
// R7 - Channel three: falling pin edge only.
// R8 - Mask: global enable plus per-channel enables.
// R9 - Software-ordered priority encoder picks one request.
// R10 - Grant disables interrupts, saves context, jumps vector.
// R11 - Service address from vector byte pair.
// R12 - Request flags latch and read while masked.
// R13 - Comparator a to channel two, b to zero.
// R14 - Edge selects in request register bits seven, six.
// R15 - Edge select codes 00,01,10,11 per pin.
// R16 - After reset program counter loads 000CH.
// R17 - Priority register write only, reads zero.
// R18 - Pins synchronized; flag clears when cycle taken.
module six_source_vectored_interrupt_unit #(
  parameter ADDR_W = 12
) (
  input wire clk,
  input wire srst,
  input wire ce,
  // AHB-Lite slave port.
  input wire hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  // Asynchronous request sources.
  input wire port3_line_0,
  input wire port3_line_1,
  input wire port3_line_2,
  input wire port3_line_3,
  input wire comparator_a_out,
  input wire comparator_b_out,
  // On-chip event pulses on this clock.
  input wire port_zero_data_available,
  input wire port_two_data_available,
  input wire timer_input_event,
  input wire timer_zero,
  input wire timer_one,
  // CPU core side.
  output wire cpu_int_req,
  input wire cpu_int_ack,
  output wire save_context,
  output wire pm_rd,
  output wire [15:0] pm_addr,
  input wire [7:0] pm_data,
  output wire isr_valid,
  output wire [15:0] isr_addr,
  output wire pc_load,
  output wire [15:0] pc_load_addr,
  output wire irq_out
);

  // ------------------------------------------------------------
  // Interrupt machine states.
  // ------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_REQ = 3'd1;
  localparam [2:0] ST_FETCH_HI = 3'd2;
  localparam [2:0] ST_FETCH_LO = 3'd3;
  localparam [2:0] ST_CAPTURE = 3'd4;
  localparam [2:0] ST_DONE = 3'd5;

  // ------------------------------------------------------------
  // Input synchronisers.
  // ------------------------------------------------------------
  // Order: line0, line1, line2, line3, comparator a, comparator b.
  wire [5:0] async_in;
  reg [5:0] sync1_ff; // First stage, read only by the second stage.
  reg [5:0] sync2_ff; // Settled level.
  reg [5:0] prev_ff; // Level one cycle earlier, for edge detection.
  wire [5:0] rise;
  wire [5:0] fall;

  assign async_in = {comparator_b_out, comparator_a_out,
                     port3_line_3, port3_line_2, port3_line_1, port3_line_0};

  // Two flip-flops before any logic looks at a pin or comparator.
  always @(posedge clk) begin
    if (srst) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
      prev_ff <= 6'h00;
    end else if (ce) begin
      sync1_ff <= async_in; // R18
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // The zero reset of the history means a pin held low at reset gives no edge.
  assign rise = sync2_ff & ~prev_ff;
  assign fall = ~sync2_ff & prev_ff;

  // ------------------------------------------------------------
  // Register state.
  // ------------------------------------------------------------
  reg [5:0] req_ff; // Request flags, one per channel.
  reg [1:0] edge_ff; // Bit 1 steers the channel-two pin, bit 0 the channel-zero pin.
  reg [7:0] mask_ff; // Global enable on top, channel enables below.
  reg [2:0] pri_ff; // Channel that wins first; order then ascends.
  reg [5:0] evt_status_ff; // Sticky event bits.
  reg [5:0] evt_enable_ff; // Event bits allowed onto irq_out.
  reg [5:0] nxt_req;
  reg [5:0] nxt_evt_status;

  // ------------------------------------------------------------
  // Per-channel source folding.
  // ------------------------------------------------------------
  reg ch0_pin_hit;
  reg ch2_pin_hit;
  wire [5:0] chan_event;

  // Edge selection: 0 picks falling, 1 picks rising, both set picks either.
  always @* begin
    case (edge_ff) // R15
      2'b00: begin
        ch0_pin_hit = fall[2] | fall[5];
        ch2_pin_hit = fall[1] | fall[4];
      end
      2'b01: begin
        ch0_pin_hit = rise[2] | rise[5];
        ch2_pin_hit = fall[1] | fall[4];
      end
      2'b10: begin
        ch0_pin_hit = fall[2] | fall[5];
        ch2_pin_hit = rise[1] | rise[4];
      end
      default: begin
        ch0_pin_hit = rise[2] | fall[2] | rise[5] | fall[5];
        ch2_pin_hit = rise[1] | fall[1] | rise[4] | fall[4];
      end
    endcase
  end

  // Comparator b rides with the channel-zero pin, comparator a with channel two.
  assign chan_event[0] = ch0_pin_hit | port_zero_data_available; // R4 R13
  assign chan_event[1] = fall[3]; // R5
  assign chan_event[2] = ch2_pin_hit | timer_input_event | port_two_data_available; // R6 R13
  assign chan_event[3] = fall[0]; // R7
  assign chan_event[4] = timer_zero; // R2
  assign chan_event[5] = timer_one; // R2

  // ------------------------------------------------------------
  // Priority encoder.
  // ------------------------------------------------------------
  wire [5:0] eligible;
  reg [2:0] win_chan;
  reg win_found;
  reg [2:0] start_chan;
  reg [3:0] probe;
  integer i;

  // A flag only competes when its own enable and the global enable are set.
  assign eligible = req_ff & mask_ff[5:0] & {6{mask_ff[`MASK_GLOBAL_BIT]}}; // R8

  // Walk the six channels from the programmed start, wrapping past five.
  always @* begin
    win_chan = 3'd0;
    win_found = 1'b0;
    start_chan = (pri_ff > 3'd5) ? 3'd0 : pri_ff;
    probe = 4'd0;
    for (i = 0; i < `NUM_CHANNELS; i = i + 1) begin
      probe = {1'b0, start_chan} + i[3:0];
      if (probe > 4'd5) begin
        probe = probe - 4'd6;
      end
      if (!win_found && eligible[probe[2:0]]) begin
        win_found = 1'b1; // R9
        win_chan = probe[2:0];
      end
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite slave.
  // ------------------------------------------------------------
  reg hreadyout_ff;
  reg hresp_ff;
  reg [31:0] hrdata_ff;
  reg wr_pend_ff; // A write data phase follows.
  reg [9:0] wr_idx_ff; // Word index of that write.
  reg [31:0] rd_word;
  wire addr_phase;
  wire [9:0] a_idx;
  wire wr_req;
  wire wr_mask;
  wire wr_pri;
  wire wr_clear;
  wire wr_enable;

  assign addr_phase = hsel & hready & (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
  assign a_idx = haddr[11:2];
  assign wr_req = wr_pend_ff && wr_idx_ff == `IDX_REQUEST_EDGE;
  assign wr_mask = wr_pend_ff && wr_idx_ff == `IDX_MASK;
  assign wr_pri = wr_pend_ff && wr_idx_ff == `IDX_PRIORITY_ORDER;
  assign wr_clear = wr_pend_ff && wr_idx_ff == `IDX_EVT_CLEAR;
  assign wr_enable = wr_pend_ff && wr_idx_ff == `IDX_EVT_ENABLE;

  // Read mux; unmapped and write-only locations answer zero.
  always @* begin
    case (a_idx)
      `IDX_REQUEST_EDGE: rd_word = {24'h0000_00, edge_ff, req_ff}; // R12 R14
      `IDX_MASK: rd_word = {24'h0000_00, mask_ff};
      `IDX_EVT_STATUS: rd_word = {26'h000_0000, evt_status_ff};
      `IDX_EVT_ENABLE: rd_word = {26'h000_0000, evt_enable_ff};
      `IDX_PRIORITY_ORDER: rd_word = 32'h0000_0000; // R17
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Zero-wait slave: read data is registered during the address phase.
  always @(posedge clk) begin
    if (srst) begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= `HRESP_OKAY;
      hrdata_ff <= 32'h0000_0000;
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 10'h000;
    end else if (ce) begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= `HRESP_OKAY;
      wr_pend_ff <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_idx_ff <= a_idx;
      end
      if (addr_phase && !hwrite) begin
        hrdata_ff <= rd_word;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt machine.
  // ------------------------------------------------------------
  reg [2:0] state_ff;
  reg [2:0] chan_ff; // Granted channel.
  reg cpu_int_req_ff;
  reg save_context_ff;
  reg pm_rd_ff;
  reg [15:0] pm_addr_ff;
  reg [7:0] vec_hi_ff;
  reg isr_valid_ff;
  reg [15:0] isr_addr_ff;
  reg pc_load_ff;
  reg pc_pending_ff; // Set by reset, consumed by the first enabled cycle.
  reg irq_out_ff;
  wire take;
  wire [15:0] vec_addr;

  assign take = (state_ff == ST_IDLE) && win_found;
  // Vector n sits at byte 2n of program memory.
  assign vec_addr = `VECTOR_BASE + {12'h000, chan_ff, 1'b0}; // R3

  // Grant, context save request and the two-byte vector fetch.
  always @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      chan_ff <= 3'd0;
      cpu_int_req_ff <= 1'b0;
      save_context_ff <= 1'b0;
      pm_rd_ff <= 1'b0;
      pm_addr_ff <= 16'h0000;
      vec_hi_ff <= 8'h00;
      isr_valid_ff <= 1'b0;
      isr_addr_ff <= 16'h0000;
    end else if (ce) begin
      save_context_ff <= 1'b0;
      isr_valid_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (take) begin
            chan_ff <= win_chan; // R10
            cpu_int_req_ff <= 1'b1;
            state_ff <= ST_REQ;
          end
        end
        ST_REQ: begin
          // The core acknowledges once it reaches an instruction boundary.
          if (cpu_int_ack) begin
            cpu_int_req_ff <= 1'b0;
            save_context_ff <= 1'b1; // R10
            pm_rd_ff <= 1'b1;
            pm_addr_ff <= vec_addr;
            state_ff <= ST_FETCH_HI;
          end
        end
        ST_FETCH_HI: begin
          pm_addr_ff <= vec_addr + 16'h0001;
          state_ff <= ST_FETCH_LO;
        end
        ST_FETCH_LO: begin
          vec_hi_ff <= pm_data; // Byte at 2n, one cycle after its address.
          pm_rd_ff <= 1'b0;
          state_ff <= ST_CAPTURE;
        end
        ST_CAPTURE: begin
          isr_addr_ff <= {vec_hi_ff, pm_data}; // R11
          isr_valid_ff <= 1'b1;
          state_ff <= ST_DONE;
        end
        ST_DONE: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
          cpu_int_req_ff <= 1'b0;
          pm_rd_ff <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Software registers and request flags.
  // ------------------------------------------------------------
  // A new event wins over both the grant clear and a software write.
  always @* begin
    nxt_req = wr_req ? hwdata[5:0] : req_ff;
    if (take) begin
      nxt_req[win_chan] = 1'b0; // R18
    end
    nxt_req = nxt_req | chan_event; // R1 R12
    nxt_evt_status = wr_clear ? (evt_status_ff & ~hwdata[5:0]) : evt_status_ff;
    nxt_evt_status = nxt_evt_status | chan_event;
  end

  always @(posedge clk) begin
    if (srst) begin
      req_ff <= `RST_REQUEST;
      edge_ff <= `RST_EDGE;
      mask_ff <= `RST_MASK;
      pri_ff <= `RST_PRIORITY;
      evt_status_ff <= `RST_EVT;
      evt_enable_ff <= `RST_EVT;
    end else if (ce) begin
      req_ff <= nxt_req;
      evt_status_ff <= nxt_evt_status;
      if (wr_req) begin
        edge_ff <= {hwdata[`REQ_EDGE_CH2_BIT], hwdata[`REQ_EDGE_CH0_BIT]}; // R14
      end
      if (wr_pri) begin
        pri_ff <= hwdata[`PRI_START_MSB:0]; // R9 R17
      end
      if (wr_enable) begin
        evt_enable_ff <= hwdata[5:0];
      end
      // The grant must close the global enable even against a same-cycle write.
      if (take) begin
        // Bit six stays clear here as well, so it always reads back zero.
        mask_ff <= wr_mask ? {2'h0, hwdata[5:0]} : (mask_ff & 8'h7F); // R10
      end else if (wr_mask) begin
        mask_ff <= {hwdata[7], 1'b0, hwdata[5:0]}; // R8
      end
    end
  end

  // ------------------------------------------------------------
  // Reset vector and summary interrupt.
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      pc_load_ff <= 1'b0;
      pc_pending_ff <= 1'b1;
      irq_out_ff <= 1'b0;
    end else if (ce) begin
      pc_load_ff <= pc_pending_ff; // R16
      pc_pending_ff <= 1'b0;
      irq_out_ff <= |(evt_status_ff & evt_enable_ff);
    end
  end

  // ------------------------------------------------------------
  // Outputs, all straight from flip-flops except pc_load_addr, which is a constant.
  // ------------------------------------------------------------
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign cpu_int_req = cpu_int_req_ff;
  assign save_context = save_context_ff;
  assign pm_rd = pm_rd_ff;
  assign pm_addr = pm_addr_ff;
  assign isr_valid = isr_valid_ff;
  assign isr_addr = isr_addr_ff;
  assign pc_load = pc_load_ff;
  assign pc_load_addr = `PC_RESET_ADDR; // R16
  assign irq_out = irq_out_ff;

endmodule

// ---- dv/irq_unit_monitor.sv ----
// Concurrent checks on the interrupt unit's ports.
`timescale 1ns/1ps
module irq_unit_monitor #(
  parameter ADDR_W = 12
) (
  input wire clk,
  input wire srst,
  input wire hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire cpu_int_req,
  input wire cpu_int_ack,
  input wire save_context,
  input wire pm_rd,
  input wire [15:0] pm_addr,
  input wire [7:0] pm_data,
  input wire isr_valid,
  input wire [15:0] isr_addr,
  input wire pc_load,
  input wire [15:0] pc_load_addr
);
  // ------------------------------------------------------------
  // One clock domain, so one default clocking and reset guard.
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // The fetch must land past the vector area on the first run cycle.
  AST_PC_RESET: assert property ($past(srst, 2) && !$past(srst) |->
    pc_load && pc_load_addr == 16'h000C) else $error("no start address load after reset");
  // The zero-wait slave is always ready and never reports an error.
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("slave not ready or error response");
  // The priority register keeps nothing readable.
  AST_PRI_WO: assert property (hsel && hready && htrans[1] && !hwrite &&
    haddr == 12'h3E4 |=> hrdata == 32'h0000_0000) else $error("priority register read back");
  // An accepted acknowledge drops the request and starts the save and fetch.
  AST_ACK_SEQ: assert property (cpu_int_req && cpu_int_ack |=>
    !cpu_int_req && save_context && pm_rd) else $error("acknowledge not followed by save");
  AST_REQ_HOLD: assert property (cpu_int_req && !cpu_int_ack |=> cpu_int_req)
    else $error("request dropped before acknowledge");
  // The first fetch is an even address inside the twelve vector bytes.
  AST_VEC_SLOT: assert property (save_context |-> !pm_addr[0] && pm_addr < 16'h000C)
    else $error("vector fetch outside vector area");
  AST_VEC_NEXT: assert property (save_context |=>
    pm_rd && pm_addr == $past(pm_addr) + 16'h0001) else $error("second vector byte not fetched");
  AST_ISR_TIME: assert property (save_context |-> ##3 isr_valid)
    else $error("service address late");
  // High byte first, low byte from the following location.
  AST_ISR_ADDR: assert property (isr_valid |->
    isr_addr == {$past(pm_data, 2), $past(pm_data)}) else $error("service address wrong");
  // Global enable is gone after a grant, so no request may follow at once.
  AST_NO_REGRANT: assert property (isr_valid |=> !cpu_int_req [*2])
    else $error("request without renewed enable");
endmodule

bind six_source_vectored_interrupt_unit irq_unit_monitor #(.ADDR_W(ADDR_W)) mon_u (.*);

// ---- dv/cpu_pm_model.sv ----
// Model of the core and program memory facing the interrupt unit.
`timescale 1ns/1ps
module cpu_pm_model (
  input wire clk,
  input wire srst,
  input wire [3:0] ack_dly,
  input wire cpu_int_req,
  output reg cpu_int_ack,
  input wire pm_rd,
  input wire [15:0] pm_addr,
  output reg [7:0] pm_data
);
  reg [3:0] wait_ff; // Cycles spent before acknowledging.
  // ------------------------------------------------------------
  // Acknowledge after a chosen delay; drop once it has been taken.
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (srst || !cpu_int_req || cpu_int_ack) begin
      cpu_int_ack <= 1'h0;
      wait_ff <= 4'h0;
    end else if (wait_ff == ack_dly) begin
      cpu_int_ack <= 1'h1;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
  // Byte a holds {a, ~a} so each vector half differs; idle data toggles.
  always @(posedge clk) begin
    if (srst) begin
      pm_data <= 8'h00;
    end else if (pm_rd) begin
      pm_data <= {pm_addr[3:0], ~pm_addr[3:0]};
    end else begin
      pm_data <= ~pm_data;
    end
  end
endmodule

// ---- dv/six_source_vectored_interrupt_unit_tb_top.sv ----
// Self-checking bench for the six-channel interrupt unit.
`timescale 1ns/1ps
module six_source_vectored_interrupt_unit_tb_top;
  reg clk = 0;
  reg srst = 1;
  reg hsel = 0;
  reg hwrite = 0;
  reg [11:0] haddr = 0;
  reg [1:0] htrans = 0;
  reg [31:0] hwdata = 0;
  reg [3:0] pin = 4'h9; // Falling-only pins idle high.
  reg [1:0] cmpv = 0; // Comparator b in bit 1, a in bit 0.
  reg [4:0] pls = 0; // Pulses: t1, t0, timer input, port two, port zero.
  reg [3:0] ack_dly = 0;
  wire hreadyout, cpu_int_req, cpu_int_ack, pm_rd, isr_valid, pc_load, irq_out;
  wire [31:0] hrdata;
  wire [15:0] pm_addr, isr_addr, pc_load_addr;
  wire [7:0] pm_data;
  integer err_total = 0;
  integer n_compared = 0;
  integer k;
  reg [15:0] lfsr = 16'h0036;
  reg [15:0] e;
  reg [31:0] q;
  reg [2:0] s;
  reg [2:0] ch;
  localparam [11:0] A_PRI = 12'h3E4, A_REQ = 12'h3E8, A_MSK = 12'h3EC;
  localparam [11:0] A_STS = 12'h400, A_CLR = 12'h404, A_ENA = 12'h408;
  // Digits: edge code, source, pin level, expected channel.
  localparam [239:0] TBL = {16'h0101, 16'h0303, 16'h0000, 16'h0202, 16'h0A02,
    16'h0404, 16'h0505, 16'h1610, 16'h2712, 16'h0600, 16'h0702, 16'h3610,
    16'h3600, 16'h3810, 16'h3912};

  always #12.5 clk = ~clk;

  six_source_vectored_interrupt_unit dut_u (
    .clk(clk), .srst(srst), .ce(1'h1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .port3_line_0(pin[0]),
    .port3_line_1(pin[1]), .port3_line_2(pin[2]), .port3_line_3(pin[3]),
    .comparator_a_out(cmpv[0]), .comparator_b_out(cmpv[1]),
    .port_zero_data_available(pls[0]), .port_two_data_available(pls[1]),
    .timer_input_event(pls[2]), .timer_zero(pls[3]), .timer_one(pls[4]),
    .cpu_int_req(cpu_int_req), .cpu_int_ack(cpu_int_ack), .save_context(),
    .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data), .isr_valid(isr_valid),
    .isr_addr(isr_addr), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
    .irq_out(irq_out));

  cpu_pm_model pm_u (.clk(clk), .srst(srst), .ack_dly(ack_dly),
    .cpu_int_req(cpu_int_req), .cpu_int_ack(cpu_int_ack), .pm_rd(pm_rd),
    .pm_addr(pm_addr), .pm_data(pm_data));

  // ------------------------------------------------------------
  // Reporting and expectations.
  // ------------------------------------------------------------
  task print_verdict;
    begin
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task hang;
    begin
      err_total = err_total + 1;
      $display("mismatch at %0t: wait ran out", $time);
      print_verdict;
    end
  endtask
  task cmp(input [31:0] g, input [31:0] x);
    begin
      n_compared = n_compared + 1;
      if (g !== x) begin
        err_total = err_total + 1;
        $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
    end
  endtask
  // The model stores {a, ~a} at byte a; vector n spans bytes 2n and 2n+1.
  function [31:0] exp_vec(input [2:0] c);
    reg [3:0] b;
    begin
      b = {c, 1'h0};
      exp_vec = {16'h0000, b, ~b, b + 4'h1, ~(b + 4'h1)};
    end
  endfunction
  function [15:0] nxt(input [15:0] x);
    nxt = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // One single transfer; each phase waits for ready under a bound.
  task bus(input w, input [11:0] a, input [31:0] d);
    integer i, ph;
    begin
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      for (ph = 0; ph < 2; ph = ph + 1) begin
        i = 0;
        @(posedge clk);
        while (hreadyout !== 1'h1) begin
          i = i + 1;
          if (i > 20) hang;
          @(posedge clk);
        end
        if (ph == 0) begin
          htrans <= 2'h0;
          hwdata <= d;
        end
      end
      q = hrdata;
    end
  endtask
  task rd(input [11:0] a, input [31:0] x);
    begin
      bus(1'h0, a, 32'h0000_0000);
      cmp(q, x);
    end
  endtask
  // Drive one source: a pin or comparator level, or a one-cycle pulse.
  task stim(input [3:0] src, input v);
    begin
      case (src)
        4'h1: pin[3] <= v;
        4'h3: pin[0] <= v;
        4'h6: pin[2] <= v;
        4'h7: pin[1] <= v;
        4'h8: cmpv[1] <= v;
        4'h9: cmpv[0] <= v;
        4'h0: pls <= 5'h01;
        4'hA: pls <= 5'h02;
        4'h2: pls <= 5'h04;
        4'h4: pls <= 5'h08;
        default: pls <= 5'h10;
      endcase
      @(posedge clk);
      pls <= 5'h00;
    end
  endtask
  // Wait for the service address and compare it with the channel's vector.
  task serve(input [2:0] c);
    integer i;
    begin
      i = 0;
      while (isr_valid !== 1'h1) begin
        i = i + 1;
        if (i > 60) hang;
        @(posedge clk);
      end
      cmp(isr_addr, exp_vec(c));
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'h0;
    repeat (2) @(posedge clk);
    cmp({pc_load, pc_load_addr}, 32'h0001_000C);
    rd(A_REQ, 32'h0000_0000);
    rd(A_MSK, 32'h0000_0000);
    rd(A_ENA, 32'h0000_0000);
    rd(12'h3F0, 32'h0000_0000);
    bus(1'h1, A_PRI, 32'h0000_0005);
    rd(A_PRI, 32'h0000_0000);
    bus(1'h1, A_MSK, 32'h0000_00FF);
    rd(A_MSK, 32'h0000_00BF);
    bus(1'h1, A_MSK, 32'h0000_003F);
    // A masked event still latches and is seen by polling.
    stim(4'h4, 1'h0);
    repeat (2) @(posedge clk);
    cmp({cpu_int_req, irq_out}, 32'h0000_0000);
    rd(A_REQ, 32'h0000_0010);
    rd(A_STS, 32'h0000_0010);
    bus(1'h1, A_ENA, 32'h0000_0010);
    repeat (2) @(posedge clk);
    cmp(irq_out, 32'h0000_0001);
    bus(1'h1, A_CLR, 32'h0000_0010);
    repeat (2) @(posedge clk);
    cmp(irq_out, 32'h0000_0000);
    rd(A_STS, 32'h0000_0000);
    // Every source, edge code and comparator routed to its channel.
    for (k = 0; k < 15; k = k + 1) begin
      e = TBL[(14 - k) * 16 +: 16];
      lfsr = nxt(lfsr);
      ack_dly <= lfsr[3:0];
      bus(1'h1, A_REQ, {24'h00_0000, e[13:12], 6'h00});
      bus(1'h1, A_MSK, {24'h00_0000, 8'h80 | (8'h01 << e[2:0])});
      stim(e[11:8], e[4]);
      serve(e[2:0]);
    end
    // All six pending: the priority start decides; start 7 is tried first.
    for (k = 0; k < 6; k = k + 1) begin
      lfsr = nxt(lfsr);
      s = (k == 0) ? 3'h7 : lfsr[2:0];
      ch = (s > 3'h5) ? 3'h0 : s;
      ack_dly <= lfsr[7:4];
      bus(1'h1, A_REQ, 32'h0000_003F);
      bus(1'h1, A_PRI, {29'h0000_0000, s});
      bus(1'h1, A_MSK, 32'h0000_00BF);
      serve(ch);
      rd(A_REQ, 32'h0000_003F & ~(32'h0000_0001 << ch));
    end
    print_verdict;
  end
endmodule
